// ---- ioam_far.sv ----
`timescale 1ns/1ps
// Wired equipment and network host; levels move only after an edge
module ioam_far (
   input wire pclk,
   input wire [7:0] din_req,
   input wire [15:0] rin_req,
   output reg [7:0] din,
   output reg [15:0] rin_bits
);
   // Connector levels and host bits travel separate paths
   always @(posedge pclk) begin
      din <= din_req;
      rin_bits <= rin_req;
   end
endmodule // ioam_far

// ---- ioam_matrix.v ----
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "ioam_regs.vh"
module ioam_matrix #(
   parameter NDIN = 8,
   parameter NDOUT = 8,
   parameter NRIN = 16,
   parameter NROUT = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   input wire [NDIN-1:0] din,
   output reg [NDOUT-1:0] dout,
   input wire [NRIN-1:0] rin_bits,
   output reg [NROUT-1:0] rout_bits,
   output reg [63:0] fn_in_active,
   input wire [63:0] fn_out_state
);
   localparam CW = `IOAM_CODE_W;

   ////////////////////////////////////////////////////////////////////////
   // Assignment storage, kept in flops since every entry is used at once
   reg [NDIN*CW-1:0] din_cfg_r;
   reg [NDOUT*CW-1:0] dout_cfg_r;
   reg [NRIN*CW-1:0] rin_cfg_r;
   reg [NROUT*CW-1:0] rout_cfg_r;
   wire [NDIN-1:0] din_s;
   wire [63:0] fn_in_nxt;

   // Network bits are same-clock logic and skip the synchroniser
   // Wired pins come from outside the clock domain
   ioam_sync #(.W(NDIN)) u_din_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(din),
      .q(din_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // APB decode
   // Only the low byte selects a register; upper address bits must be zero
   wire [5:0] idx = paddr[7:2];
   wire [5:0] code_w = pwdata[`IOAM_CODE_LSB +: CW];
   wire is_din = idx < 6'h08;
   wire is_dout = idx >= 6'h08 && idx < 6'h10;
   wire is_rin = idx >= 6'h10 && idx < 6'h20;
   wire is_rout = idx >= 6'h20 && idx < 6'h30;
   wire is_stat = idx >= 6'h30 && idx < 6'h34;
   wire addr_ok = paddr[11:8] == 4'h0 && paddr[1:0] == 2'h0;
   wire [3:0] sub = idx[3:0];
   reg bad_nxt;
   reg [31:0] rd_nxt;

   // Codes that may not land on a given side are refused
   wire din_refuse = code_w >= `IOAM_FI_NET_GEN &&
      code_w < `IOAM_FI_NET_GEN + 6'h10;
   wire rin_refuse = code_w == `IOAM_FI_ESTOP ||
      (code_w >= `IOAM_FI_LOCAL_GEN && code_w < `IOAM_FI_NET_GEN);

   // Always ready: every access completes in its first access cycle
   // Wait states are never needed since both answers come from flops
   assign pready = 1'b1;

   // Error and read data decided in the setup cycle, so both come from flops
   always @* begin
      bad_nxt = 1'b0;
      rd_nxt = 32'h0000_0000;
      if (!addr_ok) begin
         bad_nxt = 1'b1;
      end else if (is_din) begin
         rd_nxt[CW-1:0] = din_cfg_r[sub[2:0]*CW +: CW];
         bad_nxt = pwrite && din_refuse;
      end else if (is_dout) begin
         rd_nxt[CW-1:0] = dout_cfg_r[sub[2:0]*CW +: CW];
      end else if (is_rin) begin
         rd_nxt[CW-1:0] = rin_cfg_r[sub*CW +: CW];
         bad_nxt = pwrite && rin_refuse;
      end else if (is_rout) begin
         rd_nxt[CW-1:0] = rout_cfg_r[sub*CW +: CW];
      end else if (is_stat) begin
         // Status words show the live levels the matrix works on
         bad_nxt = pwrite; // Status is read-only
         if (paddr[7:0] == `IOAM_STAT_DIN)
            rd_nxt[NDIN-1:0] = din_s;
         else if (paddr[7:0] == `IOAM_STAT_RIN)
            rd_nxt[NRIN-1:0] = rin_bits;
         else if (paddr[7:0] == `IOAM_STAT_DOUT)
            rd_nxt[NDOUT-1:0] = dout;
         else
            rd_nxt[NROUT-1:0] = rout_bits;
      end else begin
         bad_nxt = 1'b1;
      end
   end

   // Answer registers load on the setup cycle and hold through access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
         pslverr <= bad_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assignment writes take effect at the access edge unless refused
   // A refused write is dropped whole, so no bad code reaches the map
   wire wr_go = psel && penable && pwrite && addr_ok && !bad_nxt;
   integer k;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         din_cfg_r <= `IOAM_DIN_RST;
         dout_cfg_r <= `IOAM_DOUT_RST;
         // Network terminals default to the general code of their own bit
         for (k = 0; k < NRIN; k = k + 1)
            rin_cfg_r[k*CW +: CW] <= `IOAM_FI_NET_GEN + k[5:0];
         for (k = 0; k < NROUT; k = k + 1)
            rout_cfg_r[k*CW +: CW] <= `IOAM_FO_NET_GEN + k[5:0];
      end else if (wr_go) begin
         if (is_din)
            din_cfg_r[sub[2:0]*CW +: CW] <= code_w;
         else if (is_dout)
            dout_cfg_r[sub[2:0]*CW +: CW] <= code_w;
         else if (is_rin)
            rin_cfg_r[sub*CW +: CW] <= code_w;
         else if (is_rout)
            rout_cfg_r[sub*CW +: CW] <= code_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input matrix: one combiner per function code
   // Each code scans every terminal: wide, but stateless and hazard free
   genvar f;
   generate
      for (f = 0; f < 64; f = f + 1) begin : g_fn
         localparam [5:0] FC = f;
         // Safety inputs default ON; unassigned they never block motion
         localparam SAFE = (FC == `IOAM_FI_ESTOP) ||
            (FC == `IOAM_FI_TOOL_UNLOCK_INPUT);
         reg loc_hit;
         reg loc_asg;
         reg net_hit;
         reg net_asg;
         reg act;
         integer i;
         always @* begin
            loc_hit = 1'b0;
            loc_asg = 1'b0;
            net_hit = 1'b0;
            net_asg = 1'b0;
            act = 1'b0;
            for (i = 0; i < NDIN; i = i + 1) begin
               if (din_cfg_r[i*CW +: CW] == FC) begin
                  loc_asg = 1'b1;
                  loc_hit = loc_hit | din_s[i];
               end
            end
            for (i = 0; i < NRIN; i = i + 1) begin
               if (rin_cfg_r[i*CW +: CW] == FC) begin
                  net_asg = 1'b1;
                  net_hit = net_hit | rin_bits[i];
               end
            end
            if (FC == `IOAM_FI_UNUSED)
               act = 1'b0;
            else if (SAFE && !loc_asg && !net_asg)
               act = 1'b1;
            else if (SAFE && loc_asg && net_asg)
               act = loc_hit & net_hit;
            else
               act = loc_hit | net_hit;
         end
         assign fn_in_nxt[f] = act;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Function vector and output terminals, all registered
   // Outputs lag the function states by one edge; no output path is direct
   integer m;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fn_in_active <= 64'h0000_0000_0000_0000;
         dout <= {NDOUT{1'b0}};
         rout_bits <= {NROUT{1'b0}};
      end else begin
         fn_in_active <= fn_in_nxt;
         // Code zero selects nothing, so the terminal stays OFF
         for (m = 0; m < NDOUT; m = m + 1)
            dout[m] <= dout_cfg_r[m*CW +: CW] != `IOAM_FO_NONE &&
               fn_out_state[dout_cfg_r[m*CW +: CW]];
         for (m = 0; m < NROUT; m = m + 1)
            rout_bits[m] <= rout_cfg_r[m*CW +: CW] != `IOAM_FO_NONE &&
               fn_out_state[rout_cfg_r[m*CW +: CW]];
      end
   end
endmodule // ioam_matrix

// ---- ioam_monitor.sv ----
`timescale 1ns/1ps
// Default-map checks apply only until the first write access
module ioam_monitor (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pslverr,
   input wire [7:0] din,
   input wire [7:0] dout,
   input wire [15:0] rin_bits,
   input wire [15:0] rout_bits,
   input wire [63:0] fn_in_active,
   input wire [63:0] fn_out_state
);
   reg [2:0] age_r;
   reg cfg_r;
   wire wr = psel && penable && pwrite;
   wire ok = age_r > 3'h3 && !cfg_r;
   // Age saturates; the pin path (two sync flops, then the function register) needs three edges of history
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         age_r <= 3'h0;
         cfg_r <= 1'h0;
      end else begin
         age_r <= age_r + {2'h0, age_r != 3'h7};
         cfg_r <= cfg_r | wr;
      end
   end
   default clocking dcb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////
   a_stop_map: assert property (
      ok |-> fn_in_active[1] == $past(din[0], 3)) else $error("stop map");
   a_out_map: assert property (
      ok |-> dout == {$past(fn_out_state[17:16]), $past(fn_out_state[6:1])})
      else $error("output map");
   a_net_in: assert property (
      ok |-> fn_in_active[47:32] == $past(rin_bits)) else $error("net in");
   a_net_out: assert property (
      ok |-> rout_bits == $past(fn_out_state[47:32])) else $error("net out");
   a_safety_on: assert property (
      ok |-> fn_in_active[7:6] == 2'h3) else $error("safety not on");
   a_unused_off: assert property (
      fn_in_active[0] == 1'h0) else $error("unused code active");
   a_gen_refuse: assert property (
      wr && paddr < 12'h20 && pwdata[5:4] == 2'h2 |-> pslverr)
      else $error("net general on wired input");
   a_estop_local: assert property (
      wr && paddr[11:6] == 6'h01 && pwdata[5:0] == 6'h06 |-> pslverr)
      else $error("estop on network input");
endmodule // ioam_monitor

// ---- ioam_regs.vh ----
`ifndef IOAM_REGS_VH
`define IOAM_REGS_VH

// Register byte offsets (one 32-bit word each)
`define IOAM_DIN_BASE 8'h00
`define IOAM_DOUT_BASE 8'h20
`define IOAM_RIN_BASE 8'h40
`define IOAM_ROUT_BASE 8'h80
`define IOAM_STAT_DIN 8'hc0
`define IOAM_STAT_RIN 8'hc4
`define IOAM_STAT_DOUT 8'hc8
`define IOAM_STAT_ROUT 8'hcc

// Assignment field: bits [5:0] of each assignment register
`define IOAM_CODE_W 6
`define IOAM_CODE_LSB 0

// Input function codes
`define IOAM_FI_UNUSED 6'h00
`define IOAM_FI_STOP 6'h01
`define IOAM_FI_ROBOT_DEENERGIZE 6'h02
`define IOAM_FI_DRIVER_OVERTRAVEL_CLEAR 6'h03
`define IOAM_FI_ALARM_CLEAR 6'h04
`define IOAM_FI_PAUSE 6'h05
`define IOAM_FI_ESTOP 6'h06
`define IOAM_FI_TOOL_UNLOCK_INPUT 6'h07
`define IOAM_FI_LOCAL_GEN 6'h10
`define IOAM_FI_NET_GEN 6'h20

// Output function codes
`define IOAM_FO_NONE 6'h00
`define IOAM_FO_READY 6'h01
`define IOAM_FO_MOVING 6'h02
`define IOAM_FO_DRIVER_OVERTRAVEL_MONITOR 6'h03
`define IOAM_FO_ALARM_ACTIVE_LOW 6'h04
`define IOAM_FO_HOLD_IN_PROGRESS 6'h05
`define IOAM_FO_PROGRAM_EXECUTING 6'h06
`define IOAM_FO_LOCAL_GEN 6'h10
`define IOAM_FO_NET_GEN 6'h20

// Reset assignments, terminal 7 in the top six bits
`define IOAM_DIN_RST {6'h11, 6'h10, 6'h00, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01}
`define IOAM_DOUT_RST {6'h11, 6'h10, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01}

`endif

// ---- ioam_sync.v ----
`timescale 1ns/1ps
// Two-flop synchroniser for pin levels
module ioam_sync #(
   parameter W = 8
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   // First stage feeds only the second stage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end else begin
         meta_r <= d;
         sync_r <= meta_r;
      end
   end

   assign q = sync_r;
endmodule // ioam_sync

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
   reg pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
   reg pwrite = 1'h0;
   reg [11:0] paddr = 12'h0;
   reg [31:0] pwdata = 32'h0;
   reg [7:0] din_req = 8'h0;
   reg [15:0] rin_req = 16'h0;
   reg [63:0] fos = 64'h0, xf;
   wire [31:0] prdata;
   wire pready, pslverr;
   wire [7:0] din, dout;
   wire [15:0] rin_bits, rout_bits;
   wire [63:0] fn_in_active;
   integer err_total = 0, tests_run = 0, i, c, k;
   integer cfg [0:47];
   reg [31:0] rd;
   reg e, l, n, hl, hn;
   reg [15:0] xd, xo;
   ioam_matrix ioam_matrix_i (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .din, .dout, .rin_bits,
      .rout_bits, .fn_in_active, .fn_out_state(fos));
   ioam_far ioam_far_i (.pclk, .din_req, .rin_req, .din, .rin_bits);
   initial forever #5 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////
   task chk(input [63:0] nm, input [63:0] x, input [63:0] g);
      begin
         tests_run = tests_run + 1;
         if (g !== x) begin
            err_total = err_total + 1;
            $display("Error %0s expected %h seen %h", nm, x, g);
         end
      end
   endtask
   // Request held until pready is sampled high
   task apb(input [11:0] a, input [31:0] d, input w);
      begin
         psel <= 1'h1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'h1;
         @(posedge pclk);
         while (pready !== 1'h1) @(posedge pclk);
         rd = prdata;
         e = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
         @(posedge pclk);
      end
   endtask
   // Refused writes leave the model unchanged
   task wr(input integer t, input [5:0] v);
      reg ok;
      begin
         ok = !(t < 8 && v[5:4] == 2'h2) &&
            !(t > 15 && t < 32 && (v == 6'h06 || v[5:4] == 2'h1));
         apb({t[9:0], 2'h0}, {26'h0, v}, 1'h1);
         chk("wr_err", !ok, e);
         if (ok) cfg[t] = v;
         apb({t[9:0], 2'h0}, 32'h0, 1'h0);
         chk("cfg", cfg[t], rd);
      end
   endtask
   // Random levels, then model against all results
   task step;
      begin
         c = $urandom;
         din_req <= c[7:0];
         rin_req <= c[23:8];
         fos <= {$urandom, $urandom};
         repeat (6) @(posedge pclk);
         xf = 64'h0;
         for (c = 1; c < 64; c = c + 1) begin
            {l, n, hl, hn} = 4'h0;
            for (i = 0; i < 32; i = i + 1)
               if (cfg[i] == c && i < 8) {hl, l} = {1'h1, l | din_req[i]};
               else if (cfg[i] == c && i > 15)
                  {hn, n} = {1'h1, n | rin_req[i - 16]};
            xf[c] = (c == 6 || c == 7) ?
               (!hl && !hn) | (l && n) | (l && !hn) | (n && !hl) : l | n;
         end
         for (i = 0; i < 16; i = i + 1) begin
            xd[i] = i < 8 && cfg[8 + i] != 0 && fos[cfg[8 + i]];
            xo[i] = cfg[32 + i] != 0 && fos[cfg[32 + i]];
         end
         chk("fn_in", xf, fn_in_active);
         chk("dout", xd[7:0], dout);
         chk("rout", xo, rout_bits);
         chk("pready", 1'h1, pready);
         apb(12'h0c0, 32'h0, 1'h0);
         chk("st_din", din_req, rd);
         apb(12'h0c4, 32'h0, 1'h0);
         chk("st_rin", rin_req, rd);
         apb(12'h0c8, 32'h0, 1'h0);
         chk("st_dout", xd[7:0], rd);
         apb(12'h0cc, 32'h0, 1'h0);
         chk("st_rout", xo, rd);
      end
   endtask
   task results;
      begin
         if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // Hang guard, far beyond the roughly 780 cycles needed
   initial begin
      #100000;
      err_total = err_total + 1;
      results;
   end
   // Reset, defaults, fixed and random maps, unmapped access
   initial begin
      c = $urandom(74821);
      for (k = 0; k < 48; k = k + 1)
         cfg[k] = k > 15 ? 32 + k % 16 : k % 8 < 6 ? k % 8 + 1 : k % 8 + 10;
      cfg[5] = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      for (k = 0; k < 48; k = k + 1) begin
         apb({k[9:0], 2'h0}, 32'h0, 1'h0);
         chk("cfg", cfg[k], rd);
      end
      repeat (6) step;
      wr(0, 6'h04);
      wr(1, 6'h04);
      wr(5, 6'h07);
      wr(19, 6'h07);
      wr(2, 6'h06);
      wr(20, 6'h06);
      wr(3, 6'h21);
      wr(21, 6'h11);
      wr(9, 6'h00);
      repeat (6) step;
      for (k = 0; k < 40; k = k + 1) begin
         c = $urandom;
         wr($urandom % 48, c[5:0]);
      end
      repeat (6) step;
      apb(12'h0d0, 32'h0, 1'h0);
      chk("bad_err", 1'h1, e);
      chk("bad_rd", 32'h0, rd);
      apb(12'h0c8, 32'h1, 1'h1);
      chk("st_err", 1'h1, e);
      apb(12'h002, 32'h1, 1'h1);
      chk("al_err", 1'h1, e);
      apb(12'h000, 32'h0, 1'h0);
      chk("cfg", cfg[0], rd);
      results;
   end
endmodule // testbench
bind ioam_matrix ioam_monitor ioam_monitor_i (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pslverr, .din, .dout, .rin_bits, .rout_bits,
   .fn_in_active, .fn_out_state);
